// >>> hw/maf_i2c_front.sv
// Multi-address I2C slave front end with APB register access
// Notes on behaviour
// - Status read returns the live status word: ID, ack, direction, stop, start.
// - ACK config write keeps low five bits; ID is value shifted right one.
// - Table entry becomes 0x00 when disabled, 0xF when enabled.
// - ACK query read takes ID from request, returns stored table entry.
// - Data edge samples clock bit 3, data bit 2; data low, clock high starts.
// - Start clears clock request, sets start flag, selects await, unmasks clock.
// - Stop sets stop flag, masks clock events, restores clock edge setup.
// - Idle handler clears and unmasks data event, masks clock events.
// - First clock after start masks data, stops fall detect, preloads 0x01.
// - Each capture rise clears stop flag, shifts data in, MSB first.
// - Byte complete when sentinel leaves; last bit becomes direction flag.
// - Upper seven bits checked against own table; no match goes unselected.
// - Match writes ID to status upper nibble and loads its ACK enable.
// - Ack start stops rise detect, copies enable to ack flag, waits clock low.
// - After clock low, data driven low for ACK, released for NACK.
// - Then fall detect enabled and ack completion handler selected.
// - Each enabled clock event captures line levels and runs stored handler.
// - Ack completion stretches clock low, releases data, re-enables rise.
// - Unselected device counts the ack slot rise and eight data bit rises, then returns to idle.
`timescale 1ns/1ps
`default_nettype none
module maf_i2c_front (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe_n,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_n
);
   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   maf_pkg::maf_status_type   status_reg;
   maf_pkg::maf_edge_ctl_type ctl_reg;
   maf_pkg::maf_state_type    state_reg;
   logic        scl_m_reg, scl_s_reg, scl_d_reg;
   logic        sda_m_reg, sda_s_reg, sda_d_reg;
   logic        clk_req_reg, dat_req_reg;
   logic [7:0]  shift_reg;
   logic [7:0]  line_reg;
   logic [3:0]  pending_reg;
   logic [3:0]  skip_reg;
   logic [4:0]  ack_qry_reg;
   logic        scl_hold_reg;
   logic        sda_low_reg;
   logic [31:0] prdata_reg;
   logic        pslverr_reg;
   logic [3:0]  ack_tbl [maf_pkg::NUM_IDS];
   logic [7:0]  own_tbl [maf_pkg::NUM_IDS];
   logic [maf_pkg::NUM_IDS-1:0] match_vec;
   logic [3:0]  match_id;
   logic        clk_edge_hit, dat_edge_hit;
   logic        clk_fire, dat_fire;
   logic        start_go, stop_go;
   logic        byte_done;
   logic        setup_rd, wr_go;
   logic        own_hit, mapped;
   logic [31:0] rd_data;
   logic [4:0]  cfg_arg;

   // ------------------------------------------------------------
   // Line synchronisers and edge finders
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_m_reg <= 1'b1;
         scl_s_reg <= 1'b1;
         scl_d_reg <= 1'b1;
         sda_m_reg <= 1'b1;
         sda_s_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_m_reg <= scl_i;
         scl_s_reg <= scl_m_reg;
         scl_d_reg <= scl_s_reg;
         sda_m_reg <= sda_i;
         sda_s_reg <= sda_m_reg;
         sda_d_reg <= sda_s_reg;
      end
   end

   assign clk_edge_hit = (ctl_reg.rise_det & scl_s_reg & ~scl_d_reg)
                       | (ctl_reg.fall_det & ~scl_s_reg & scl_d_reg);
   assign dat_edge_hit = sda_s_reg ^ sda_d_reg;
   assign dat_fire     = dat_req_reg & ~ctl_reg.dat_mask;
   assign clk_fire     = clk_req_reg & ~ctl_reg.clk_mask & ~dat_fire;
   assign start_go     = dat_fire & scl_s_reg & ~sda_s_reg;
   assign stop_go      = dat_fire & scl_s_reg & sda_s_reg;
   assign byte_done    = clk_fire && state_reg == maf_pkg::ST_CAPTURE
                         && shift_reg[7];

   // ------------------------------------------------------------
   // Edge requests, new edge wins over a clear
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_req_reg <= 1'b0;
         dat_req_reg <= 1'b0;
      end else begin
         clk_req_reg <= clk_edge_hit
                        | (clk_req_reg & ~clk_fire & ~start_go);
         dat_req_reg <= dat_edge_hit | (dat_req_reg & ~dat_fire
                        & ~(clk_fire && state_reg == maf_pkg::ST_WATCH));
      end
   end

   // ------------------------------------------------------------
   // Own address compare
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < maf_pkg::NUM_IDS; gi++) begin : g_own
         if (gi == 0) begin : g_none
            assign own_tbl[gi]   = maf_pkg::OWN_RESET;
            assign match_vec[gi] = 1'b0;
         end else begin : g_ent
            logic [7:0] ent_reg;
            always_ff @(posedge pclk or negedge presetn) begin
               if (!presetn) begin
                  ent_reg <= maf_pkg::OWN_RESET;
               end else if (wr_go && own_hit && paddr[5:2] == 4'(gi)) begin
                  ent_reg <= pwdata[7:0];
               end
            end
            assign own_tbl[gi]   = ent_reg;
            assign match_vec[gi] = ent_reg[maf_pkg::OWN_VALID_BIT]
                                   && ent_reg[6:0] == shift_reg[6:0];
         end
      end
   endgenerate

   always_comb begin
      match_id = 4'h0;
      for (int i = maf_pkg::NUM_IDS - 1; i > 0; i--) begin
         if (match_vec[i]) begin
            match_id = 4'(i);
         end
      end
   end

   // ------------------------------------------------------------
   // Handler sequencer
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg    <= maf_pkg::ST_WATCH;
         ctl_reg      <= maf_pkg::EDGE_INIT;
         status_reg   <= '0;
         shift_reg    <= 8'h00;
         pending_reg  <= maf_pkg::ACK_OFF;
         skip_reg     <= 4'h0;
         scl_hold_reg <= 1'b0;
         sda_low_reg  <= 1'b0;
      end else if (start_go) begin
         status_reg.start_seen <= 1'b1;
         state_reg             <= maf_pkg::ST_AWAIT;
         ctl_reg.clk_mask      <= 1'b0;
         ctl_reg.fall_det      <= 1'b1;
         scl_hold_reg          <= 1'b0;
         sda_low_reg           <= 1'b0;
      end else if (stop_go) begin
         status_reg.stop_seen <= 1'b1;
         ctl_reg              <= maf_pkg::EDGE_INIT;
         state_reg            <= maf_pkg::ST_WATCH;
         scl_hold_reg         <= 1'b0;
         sda_low_reg          <= 1'b0;
      end else if (state_reg == maf_pkg::ST_WAIT_LOW) begin
         if (!scl_s_reg) begin
            sda_low_reg      <= pending_reg != maf_pkg::ACK_OFF;
            ctl_reg.fall_det <= 1'b1;
            state_reg        <= maf_pkg::ST_ACK_END;
         end
      end else if (state_reg == maf_pkg::ST_HOLD) begin
         if (wr_go && paddr == maf_pkg::ADDR_CTRL
             && pwdata[maf_pkg::CTRL_RELEASE]) begin
            scl_hold_reg <= 1'b0;
            state_reg    <= maf_pkg::ST_WATCH;
            ctl_reg      <= maf_pkg::EDGE_INIT;
         end
      end else if (clk_fire) begin
         unique case (state_reg)
            maf_pkg::ST_WATCH: begin
               ctl_reg.dat_mask <= 1'b0;
               ctl_reg.clk_mask <= 1'b1;
            end
            maf_pkg::ST_AWAIT: begin
               ctl_reg.dat_mask <= 1'b1;
               ctl_reg.fall_det <= 1'b0;
               shift_reg        <= maf_pkg::SHIFT_SENTINEL;
               state_reg        <= maf_pkg::ST_CAPTURE;
            end
            maf_pkg::ST_CAPTURE: begin
               status_reg.stop_seen <= 1'b0;
               shift_reg <= {shift_reg[6:0], sda_s_reg};
               if (shift_reg[7]) begin
                  status_reg.direction <= sda_s_reg;
                  if (match_id == 4'h0) begin
                     state_reg <= maf_pkg::ST_UNSEL;
                     skip_reg  <= maf_pkg::SKIP_COUNT;
                  end else begin
                     status_reg.id       <= match_id;
                     pending_reg         <= ack_tbl[match_id];
                     ctl_reg.rise_det    <= 1'b0;
                     status_reg.ack_sent <= ack_tbl[match_id]
                                            != maf_pkg::ACK_OFF;
                     state_reg           <= maf_pkg::ST_WAIT_LOW;
                  end
               end
            end
            maf_pkg::ST_ACK_END: begin
               scl_hold_reg     <= 1'b1;
               sda_low_reg      <= 1'b0;
               ctl_reg.rise_det <= 1'b1;
               ctl_reg.fall_det <= 1'b0;
               state_reg        <= maf_pkg::ST_HOLD;
            end
            maf_pkg::ST_UNSEL: begin
               // Ack slot rise, then eight skipped data bits
               if (scl_s_reg) begin
                  if (skip_reg == 4'h0) begin
                     state_reg <= maf_pkg::ST_WATCH;
                  end else begin
                     skip_reg <= skip_reg - 4'h1;
                  end
               end
            end
            default: begin
               state_reg <= maf_pkg::ST_WATCH;
            end
         endcase
      end
   end

   // Line levels captured at each dispatched event
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_reg <= 8'h00;
      end else if (clk_fire || dat_fire) begin
         line_reg <= 8'h00;
         line_reg[maf_pkg::LINE_CLK_BIT]  <= scl_s_reg;
         line_reg[maf_pkg::LINE_DATA_BIT] <= sda_s_reg;
      end
   end

   // ------------------------------------------------------------
   // Open-drain pins
   // ------------------------------------------------------------
   assign scl_o    = 1'b0;
   assign sda_o    = 1'b0;
   assign scl_oe_n = ~scl_hold_reg;
   assign sda_oe_n = ~sda_low_reg;

   // ------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------
   assign setup_rd = psel & ~penable;
   assign wr_go    = psel & penable & pwrite;
   assign own_hit  = paddr[7:6] == maf_pkg::OWN_REGION
                     && paddr[1:0] == 2'b00;
   assign mapped   = own_hit || paddr == maf_pkg::ADDR_STATUS
                     || paddr == maf_pkg::ADDR_ACK_CFG
                     || paddr == maf_pkg::ADDR_ACK_QRY
                     || paddr == maf_pkg::ADDR_LINE
                     || paddr == maf_pkg::ADDR_CTRL;
   assign cfg_arg  = pwdata[4:0] & maf_pkg::ACK_ARG_MASK;

   always_comb begin
      rd_data = 32'h0000_0000;
      if (own_hit) begin
         rd_data[7:0] = own_tbl[paddr[5:2]];
      end else if (paddr == maf_pkg::ADDR_STATUS) begin
         rd_data[7:0] = status_reg;
      end else if (paddr == maf_pkg::ADDR_ACK_QRY) begin
         rd_data[3:0] = ack_tbl[ack_qry_reg[4:1]];
      end else if (paddr == maf_pkg::ADDR_LINE) begin
         rd_data[7:0] = line_reg;
      end else if (paddr == maf_pkg::ADDR_CTRL) begin
         rd_data[2:0] = state_reg;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else if (setup_rd) begin
         prdata_reg  <= rd_data;
         pslverr_reg <= ~mapped;
      end
   end

   assign prdata  = prdata_reg;
   assign pslverr = pslverr_reg;
   assign pready  = psel & penable;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_qry_reg <= 5'h00;
         for (int i = 0; i < maf_pkg::NUM_IDS; i++) begin
            ack_tbl[i] <= maf_pkg::ACK_OFF;
         end
      end else if (wr_go && paddr == maf_pkg::ADDR_ACK_CFG) begin
         ack_tbl[cfg_arg[4:1]] <= cfg_arg[0] ? maf_pkg::ACK_ON
                                             : maf_pkg::ACK_OFF;
      end else if (wr_go && paddr == maf_pkg::ADDR_ACK_QRY) begin
         ack_qry_reg <= cfg_arg;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_status_read;
      @(posedge pclk) disable iff (!presetn)
      setup_rd && paddr == maf_pkg::ADDR_STATUS
      |=> prdata[7:0] == $past(status_reg) && prdata[31:8] == 24'h0;
   endproperty
   a_status_read: assert property (p_status_read)
      else $error("status read mismatch");

   property p_ack_cfg;
      @(posedge pclk) disable iff (!presetn)
      wr_go && paddr == maf_pkg::ADDR_ACK_CFG
      |=> ack_tbl[$past(pwdata[4:1])] ==
          ($past(pwdata[0]) ? maf_pkg::ACK_ON : maf_pkg::ACK_OFF);
   endproperty
   a_ack_cfg: assert property (p_ack_cfg)
      else $error("ack table entry wrong");

   property p_start;
      @(posedge pclk) disable iff (!presetn)
      start_go |=> status_reg.start_seen && !ctl_reg.clk_mask
                   && state_reg == maf_pkg::ST_AWAIT && !clk_req_reg
                   ##1 !clk_fire;
   endproperty
   a_start: assert property (p_start)
      else $error("start handling wrong");

   property p_stop;
      @(posedge pclk) disable iff (!presetn)
      stop_go |=> status_reg.stop_seen && ctl_reg == maf_pkg::EDGE_INIT;
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop handling wrong");

   property p_await;
      @(posedge pclk) disable iff (!presetn)
      clk_fire && !start_go && !stop_go && state_reg == maf_pkg::ST_AWAIT
      |=> shift_reg == maf_pkg::SHIFT_SENTINEL && ctl_reg.dat_mask
          && !ctl_reg.fall_det && state_reg == maf_pkg::ST_CAPTURE;
   endproperty
   a_await: assert property (p_await)
      else $error("address wait setup wrong");

   property p_no_match;
      @(posedge pclk) disable iff (!presetn)
      byte_done && !start_go && !stop_go && match_id == 4'h0
      |=> state_reg == maf_pkg::ST_UNSEL
          && skip_reg == maf_pkg::SKIP_COUNT && sda_oe_n;
   endproperty
   a_no_match: assert property (p_no_match)
      else $error("unmatched address not skipped");

   property p_ack_drive;
      @(posedge pclk) disable iff (!presetn)
      state_reg == maf_pkg::ST_WAIT_LOW && !scl_s_reg
      && !start_go && !stop_go
      |=> sda_oe_n == (pending_reg == maf_pkg::ACK_OFF)
          && ctl_reg.fall_det && state_reg == maf_pkg::ST_ACK_END;
   endproperty
   a_ack_drive: assert property (p_ack_drive)
      else $error("ack response drive wrong");

   property p_ack_end;
      @(posedge pclk) disable iff (!presetn)
      clk_fire && !start_go && !stop_go
      && state_reg == maf_pkg::ST_ACK_END
      |=> !scl_oe_n && sda_oe_n && ctl_reg.rise_det
          && state_reg == maf_pkg::ST_HOLD;
   endproperty
   a_ack_end: assert property (p_ack_end)
      else $error("ack completion wrong");
endmodule : maf_i2c_front
`default_nettype wire

// >>> hw/maf_pkg.sv
// Package: register map, field layout and types of the I2C front end
package maf_pkg;
   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_STATUS  = 8'h00;
   localparam logic [7:0] ADDR_ACK_CFG = 8'h04;
   localparam logic [7:0] ADDR_ACK_QRY = 8'h08;
   localparam logic [7:0] ADDR_LINE    = 8'h0c;
   localparam logic [7:0] ADDR_CTRL    = 8'h10;
   localparam logic [1:0] OWN_REGION   = 2'h1;
   // ------------------------------------------------------------
   // Field values
   // ------------------------------------------------------------
   localparam logic [4:0] ACK_ARG_MASK   = 5'h1f;
   localparam logic [3:0] ACK_ON         = 4'hf;
   localparam logic [3:0] ACK_OFF        = 4'h0;
   localparam logic [7:0] SHIFT_SENTINEL = 8'h01;
   localparam logic [3:0] SKIP_COUNT     = 4'h8;
   localparam int         LINE_CLK_BIT   = 3;
   localparam int         LINE_DATA_BIT  = 2;
   localparam int         OWN_VALID_BIT  = 7;
   localparam int         NUM_IDS        = 16;
   localparam logic [7:0] OWN_RESET      = 8'h00;
   localparam int         CTRL_RELEASE   = 0;

   typedef struct packed {
      logic [3:0] id;
      logic       ack_sent;
      logic       direction;
      logic       stop_seen;
      logic       start_seen;
   } maf_status_type;

   typedef struct packed {
      logic rise_det;
      logic fall_det;
      logic clk_mask;
      logic dat_mask;
   } maf_edge_ctl_type;

   localparam maf_edge_ctl_type EDGE_INIT = '{1'b1, 1'b0, 1'b1, 1'b0};

   typedef enum logic [2:0] {
      ST_WATCH    = 3'b000,
      ST_AWAIT    = 3'b001,
      ST_CAPTURE  = 3'b010,
      ST_WAIT_LOW = 3'b011,
      ST_ACK_END  = 3'b100,
      ST_HOLD     = 3'b101,
      ST_UNSEL    = 3'b110
   } maf_state_type;
endpackage : maf_pkg

// >>> sim/maf_i2c_front_tb_top.sv
// Testbench of the multi-address I2C slave front end
`timescale 1ns/1ps
`default_nettype none
module maf_i2c_front_tb_top;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        scl_o;
   logic        scl_oe_n;
   logic        sda_o;
   logic        sda_oe_n;
   logic        scl_m;
   logic        sda_m;
   wire logic   scl_w;
   wire logic   sda_w;
   logic [31:0] rd;
   logic        er;
   logic        seen;
   int          failures = 0;
   int          n_compared = 0;

   // Open-drain wires with pull-ups
   assign scl_w = scl_m & (scl_oe_n | scl_o);
   assign sda_w = sda_m & (sda_oe_n | sda_o);

   maf_i2c_front dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl_w),
      .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe_n(sda_oe_n));
   maf_i2c_master mst (.pclk(pclk), .scl_w(scl_w), .sda_w(sda_w),
      .scl_m(scl_m), .sda_m(sda_m));

   // ------------------------------------------------------------
   // Bus and compare helpers
   // ------------------------------------------------------------
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
         failures++;
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rdc(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask : rdc

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      rdc("status_rst", maf_pkg::ADDR_STATUS, 32'h0);
      rdc("state_rst", maf_pkg::ADDR_CTRL, 32'h0);
      chk("oe_rst", 32'h3, {scl_oe_n, sda_oe_n});
      apb(1'b0, 8'h3c, 32'h0);
      chk("unmapped_err", 32'h1, er);
      wr(maf_pkg::ADDR_ACK_QRY, 32'h3);
      rdc("entry_rst", maf_pkg::ADDR_ACK_QRY, 32'h0);
   endtask : t_reset

   task automatic t_ack_table;
      logic [31:0] args [4] = '{32'hffffffe3, 32'h25, 32'h1f, 32'h4};
      logic [3:0]  ents [4] = '{4'hf, 4'hf, 4'hf, 4'h0};
      for (int i = 0; i < 4; i++) begin
         wr(maf_pkg::ADDR_ACK_CFG, args[i]);
         wr(maf_pkg::ADDR_ACK_QRY, args[i] & 32'h1f);
         rdc("ack_entry", maf_pkg::ADDR_ACK_QRY, {28'h0, ents[i]});
      end
      wr(maf_pkg::ADDR_ACK_QRY, 32'h3);
      rdc("entry_kept", maf_pkg::ADDR_ACK_QRY, 32'hf);
      rdc("cfg_read", maf_pkg::ADDR_ACK_CFG, 32'h0);
   endtask : t_ack_table

   task automatic t_match_ack;
      wr(8'h44, 32'haa);
      mst.start();
      mst.byte_out({7'h2a, 1'b1});
      mst.ack_clk(seen);
      chk("ack_level", 32'h0, seen);
      mst.wt(8);
      chk("stretch_on", 32'h1, {scl_oe_n, sda_oe_n});
      rdc("status_ack", maf_pkg::ADDR_STATUS, 32'h1d);
      rdc("state_hold", maf_pkg::ADDR_CTRL, 32'h5);
      wr(maf_pkg::ADDR_CTRL, 32'h1);
      rdc("state_idle", maf_pkg::ADDR_CTRL, 32'h0);
      chk("stretch_off", 32'h1, scl_oe_n);
      mst.stop();
      rdc("line_stop", maf_pkg::ADDR_LINE, 32'hc);
      apb(1'b0, maf_pkg::ADDR_STATUS, 32'h0);
      chk("stop_flag", 32'h1, rd[1]);
      chk("drive_low", 32'h0, {scl_o, sda_o});
   endtask : t_match_ack

   task automatic t_nack;
      wr(8'h48, 32'hb1);
      mst.start();
      mst.byte_out({7'h31, 1'b0});
      mst.ack_clk(seen);
      chk("nack_level", 32'h1, seen);
      mst.wt(8);
      rdc("status_nack", maf_pkg::ADDR_STATUS, 32'h21);
      wr(maf_pkg::ADDR_CTRL, 32'h1);
      mst.stop();
   endtask : t_nack

   task automatic t_unsel;
      mst.start();
      mst.byte_out({7'h55, 1'b0});
      rdc("state_unsel", maf_pkg::ADDR_CTRL, 32'h6);
      mst.ack_clk(seen);
      chk("no_ack", 32'h1, seen);
      for (int i = 0; i < 7; i++) mst.bit_out(1'b1);
      rdc("still_unsel", maf_pkg::ADDR_CTRL, 32'h6);
      mst.bit_out(1'b1);
      rdc("state_back", maf_pkg::ADDR_CTRL, 32'h0);
      chk("no_stretch", 32'h1, scl_oe_n);
      mst.stop();
      chk("clock_stalls", 32'h0, mst.stalls);
   endtask : t_unsel

   task automatic tally_and_finish;
      if (failures == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   initial begin
      repeat (40000) @(posedge pclk);
      failures++;
      tally_and_finish();
   end

   initial begin
      presetn = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h0;
      pwdata  = 32'h0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_ack_table();
      t_match_ack();
      t_nack();
      t_unsel();
      tally_and_finish();
   end
endmodule : maf_i2c_front_tb_top
`default_nettype wire

// >>> sim/maf_i2c_master.sv
// I2C bus master model driving open-drain SCL and SDA
`timescale 1ns/1ps
`default_nettype none
module maf_i2c_master (
   input  wire logic pclk,
   input  wire logic scl_w,
   input  wire logic sda_w,
   output logic      scl_m,
   output logic      sda_m
);
   int stalls = 0;

   initial begin
      scl_m = 1'b1;
      sda_m = 1'b1;
   end

   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask : wt

   // Release SCL, then wait out a stretch by the slave of up to 4000 cycles
   task automatic rise;
      int k;
      k = 0;
      scl_m <= 1'b1;
      @(posedge pclk);
      while (scl_w !== 1'b1 && k < 4000) begin
         @(posedge pclk);
         k++;
      end
      if (k == 4000) stalls++;
      wt(15);
   endtask : rise

   task automatic start;
      sda_m <= 1'b0;
      wt(16);
   endtask : start

   task automatic stop;
      scl_m <= 1'b0;
      wt(8);
      sda_m <= 1'b0;
      wt(8);
      rise();
      sda_m <= 1'b1;
      wt(16);
   endtask : stop

   task automatic bit_out(input logic b);
      scl_m <= 1'b0;
      wt(8);
      sda_m <= b;
      wt(8);
      rise();
   endtask : bit_out

   task automatic byte_out(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) bit_out(b[i]);
   endtask : byte_out

   // SDA released; level seen late in the high phase
   task automatic ack_clk(output logic seen);
      scl_m <= 1'b0;
      wt(8);
      sda_m <= 1'b1;
      wt(8);
      rise();
      seen = sda_w;
      scl_m <= 1'b0;
      wt(8);
   endtask : ack_clk
endmodule : maf_i2c_master
`default_nettype wire
